// *** hw/oers_channel.v ***
// configurable i/o channel: event routing, polarity, power-fail latch, remote setpoint watchdog
// Function
// R1 - set remote comms fail flag after five seconds without remote setpoint writes
// R2 - clear remote comms fail flag as soon as remote setpoint writes resume
// R3 - input assigned remote setpoint select makes remote setpoint used while active
// R4 - normal polarity energises relay at full control demand
// R5 - inverted polarity energises relay at zero control demand
// R6 - configurer should choose normal polarity for heat or cool outputs
// R7 - configurer should choose inverted polarity for alarm outputs
// R8 - input mode: normal acts on closed contact, inverted on open contact
// R9 - four event selectors only take effect in discrete output function
// R10 - discrete output operates when any selected event is true
// R11 - power-fail event operates discrete output after power is restored
// R12 - alarm acknowledge clears power-fail condition, no alarm message raised
// R13 - selector at none contributes no event to the or
// R14 - polarity inversion applied after the or of event sources
// R15 - power-fail latched from power-up until acknowledge, then clear
//
// Chosen here: the APB register port and the placing of the registers.
`include "oers_defines.vh"

module oers_channel #(
	parameter CNT_W = 29,
	parameter TIMEOUT_CYCLES = `OERS_RSP_TIMEOUT_SEC * `OERS_CLK_HZ,
	parameter RSP_W = 16
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// event sources from the controller core
	input wire alarm_one_event,
	input wire alarm_two_event,
	input wire alarm_three_event,
	input wire alarm_four_event,
	input wire loop_break_alarm,
	input wire sensor_break_alarm,
	input wire timer_end_status,
	input wire timer_run_status,
	input wire manual_status,
	input wire programmer_event,
	// control loop demand, high while demand is full scale
	input wire control_demand_on,
	// contact pin, high when the external contact is closed
	input wire contact_closed,
	// channel outputs
	output reg relay_drive,
	output reg remote_setpoint_select,
	output reg [RSP_W-1:0] remote_setpoint_value,
	output reg remote_comms_fail_flag,
	output reg power_fail_latched,
	output reg irq
);

	// configuration registers
	reg [2:0] channel_function;
	reg channel_polarity;
	reg [2:0] din_function;
	reg [`OERS_SRC_W*4-1:0] src_sel;
	reg [`OERS_INT_W-1:0] int_enable;
	reg [`OERS_INT_W-1:0] int_status;

	// apb phase decode, access completes on the cycle pready is high
	wire apb_access = psel & penable;
	wire apb_done = apb_access & pready;
	wire apb_wr = apb_done & pwrite;

	// address decode, one aligned word per register
	reg addr_ok;
	always @* begin
		addr_ok = 1'b0;
		case (paddr)
			`OERS_OFS_CTRL, `OERS_OFS_SRC, `OERS_OFS_RSP, `OERS_OFS_ACK: begin
				addr_ok = 1'b1;
			end
			`OERS_OFS_STATUS, `OERS_OFS_INT_STATUS: begin
				addr_ok = 1'b1;
			end
			`OERS_OFS_INT_CLEAR, `OERS_OFS_INT_ENABLE: begin
				addr_ok = 1'b1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// register write strobes
	wire wr_ctrl = apb_wr && (paddr == `OERS_OFS_CTRL);
	wire wr_src = apb_wr && (paddr == `OERS_OFS_SRC);
	wire wr_rsp = apb_wr && (paddr == `OERS_OFS_RSP);
	wire wr_ack = apb_wr && (paddr == `OERS_OFS_ACK) && pwdata[`OERS_ACK_BIT];
	wire wr_iclr = apb_wr && (paddr == `OERS_OFS_INT_CLEAR);
	wire wr_ien = apb_wr && (paddr == `OERS_OFS_INT_ENABLE);

	// contact synchroniser, three stages
	reg din_s1;
	reg din_s2;
	reg din_s3;
	reg din_closed;

	// internal state
	wire rsp_fail;
	reg rsp_fail_d;
	reg din_active;
	reg din_active_d;
	reg event_or;

	// one wait state: pready rises in the second access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= apb_access & ~pready;
		end
	end

	// error answer, high only in the cycle that pready is high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (apb_access & ~pready) begin
			pslverr <= ~addr_ok;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// read data, prepared together with pready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (apb_access & ~pready) begin
			prdata <= 32'h00000000;
			if (!pwrite) begin
				case (paddr)
					`OERS_OFS_CTRL: begin
						prdata[`OERS_CTRL_FUNC_MSB:`OERS_CTRL_FUNC_LSB] <= channel_function;
						prdata[`OERS_CTRL_POL_BIT] <= channel_polarity;
						prdata[`OERS_CTRL_DIN_MSB:`OERS_CTRL_DIN_LSB] <= din_function;
					end
					`OERS_OFS_SRC: begin
						prdata[`OERS_SRC_W*4-1:0] <= src_sel;
					end
					`OERS_OFS_RSP: begin
						prdata[RSP_W-1:0] <= remote_setpoint_value;
					end
					`OERS_OFS_STATUS: begin
						prdata[5:0] <= {event_or, remote_setpoint_select, din_active,
							power_fail_latched, remote_comms_fail_flag, relay_drive};
					end
					`OERS_OFS_INT_STATUS: begin
						prdata[`OERS_INT_W-1:0] <= int_status;
					end
					`OERS_OFS_INT_ENABLE: begin
						prdata[`OERS_INT_W-1:0] <= int_enable;
					end
					default: begin
						prdata <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// configuration register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_function <= `OERS_RST_FUNC;
			channel_polarity <= `OERS_RST_POL;
			din_function <= `OERS_RST_DIN;
			src_sel <= `OERS_RST_SRC;
			int_enable <= `OERS_RST_INT_ENABLE;
		end else begin
			if (wr_ctrl) begin
				channel_function <= pwdata[`OERS_CTRL_FUNC_MSB:`OERS_CTRL_FUNC_LSB];
				channel_polarity <= pwdata[`OERS_CTRL_POL_BIT];
				din_function <= pwdata[`OERS_CTRL_DIN_MSB:`OERS_CTRL_DIN_LSB];
			end
			if (wr_src) begin
				src_sel <= pwdata[`OERS_SRC_W*4-1:0];
			end
			if (wr_ien) begin
				int_enable <= pwdata[`OERS_INT_W-1:0];
			end
		end
	end

	// remote setpoint value, each write also feeds the watchdog
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_setpoint_value <= `OERS_RST_RSP;
		end else if (wr_rsp) begin
			remote_setpoint_value <= pwdata[RSP_W-1:0];
		end
	end

	// idle timer on remote setpoint writes
	oers_rsp_watchdog #(
		.CNT_W(CNT_W),
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) oers_rsp_watchdog_inst (
		.pclk(pclk),
		.presetn(presetn),
		.kick(wr_rsp), // [R2]
		.fail(rsp_fail) // [R1]
	);

	// contact pin synchroniser; a change counts once stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
			din_s3 <= 1'b0;
			din_closed <= 1'b0;
		end else begin
			din_s1 <= contact_closed;
			din_s2 <= din_s1;
			din_s3 <= din_s2;
			if (din_s2 == din_s3) begin
				din_closed <= din_s3;
			end
		end
	end

	// input meaning: closed under normal, open under inverted
	wire din_mode = (channel_function == `OERS_FUNC_DIN);
	wire din_level = din_mode & (din_closed ^ channel_polarity); // [R8]
	wire din_ack_edge = din_level & ~din_active & (din_function == `OERS_DIN_ACK);

	// acknowledge from software or from the input's alarm acknowledge function
	wire ack = wr_ack | din_ack_edge;

	// event vector indexed by source code; code 0 stays low
	wire [15:0] events;
	assign events[0] = 1'b0; // [R13]
	assign events[1] = alarm_one_event;
	assign events[2] = alarm_two_event;
	assign events[3] = alarm_three_event;
	assign events[4] = alarm_four_event;
	assign events[5] = loop_break_alarm;
	assign events[6] = sensor_break_alarm;
	assign events[7] = timer_end_status;
	assign events[8] = timer_run_status;
	assign events[9] = manual_status;
	assign events[`OERS_SRC_RFAIL] = remote_comms_fail_flag;
	assign events[`OERS_SRC_PFAIL] = power_fail_latched; // [R11]
	assign events[12] = programmer_event;
	assign events[15:13] = 3'h0; // unused codes behave as none

	// one event per selector
	wire [3:0] sel_hit;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sel
			wire [`OERS_SRC_W-1:0] code = src_sel[gi*`OERS_SRC_W +: `OERS_SRC_W];
			assign sel_hit[gi] = events[code];
		end
	endgenerate

	// or of all four selectors, only in discrete output function
	wire dout_mode = (channel_function == `OERS_FUNC_DOUT);
	wire next_event_or = dout_mode & (|sel_hit); // [R9] [R10]

	// heating or cooling output follows the demand
	wire ctl_mode = (channel_function == `OERS_FUNC_HEAT) ||
		(channel_function == `OERS_FUNC_COOL);

	// final pin drive, polarity applied after the or
	reg next_relay_drive;
	always @* begin
		next_relay_drive = 1'b0;
		if (dout_mode) begin
			next_relay_drive = next_event_or ^ channel_polarity; // [R14]
		end else if (ctl_mode) begin
			next_relay_drive = control_demand_on ^ channel_polarity; // [R4] [R5]
		end
	end

	// relay drive and event or registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_drive <= 1'b0;
			event_or <= 1'b0;
		end else begin
			relay_drive <= next_relay_drive;
			event_or <= next_event_or;
		end
	end

	// input, select and flag registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_active <= 1'b0;
			din_active_d <= 1'b0;
			remote_setpoint_select <= 1'b0;
			remote_comms_fail_flag <= 1'b0;
			rsp_fail_d <= 1'b0;
		end else begin
			din_active <= din_level;
			din_active_d <= din_active;
			remote_setpoint_select <= din_level && (din_function == `OERS_DIN_RSP_SEL); // [R3]
			remote_comms_fail_flag <= rsp_fail; // [R1] [R2]
			rsp_fail_d <= remote_comms_fail_flag;
		end
	end

	// power-fail latch: set by power-up reset, cleared only by acknowledge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_fail_latched <= 1'b1; // [R15]
		end else if (ack) begin
			power_fail_latched <= 1'b0; // [R12] [R15]
		end
	end

	// interrupt events; power-fail deliberately raises none
	wire [`OERS_INT_W-1:0] int_set;
	assign int_set[`OERS_INT_RFAIL_SET] = remote_comms_fail_flag & ~rsp_fail_d;
	assign int_set[`OERS_INT_RFAIL_CLR] = ~remote_comms_fail_flag & rsp_fail_d;
	assign int_set[`OERS_INT_DIN_ACT] = din_active & ~din_active_d;

	// sticky status, a new event wins over a clear in the same cycle
	wire [`OERS_INT_W-1:0] int_clr = wr_iclr ? pwdata[`OERS_INT_W-1:0] : {`OERS_INT_W{1'b0}};
	wire [`OERS_INT_W-1:0] next_int_status = (int_status & ~int_clr) | int_set;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= {`OERS_INT_W{1'b0}};
		end else begin
			int_status <= next_int_status;
		end
	end

	// level interrupt, high while an enabled status bit is set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_int_status & int_enable);
		end
	end

endmodule // oers_channel

// *** hw/oers_defines.vh ***
// register map, field layout, codes and timing constants of the event-routing channel
`ifndef OERS_DEFINES_VH
`define OERS_DEFINES_VH

// register byte offsets
`define OERS_OFS_CTRL 8'h00
`define OERS_OFS_SRC 8'h04
`define OERS_OFS_RSP 8'h08
`define OERS_OFS_ACK 8'h0C
`define OERS_OFS_STATUS 8'h10
`define OERS_OFS_INT_STATUS 8'h14
`define OERS_OFS_INT_CLEAR 8'h18
`define OERS_OFS_INT_ENABLE 8'h1C

// control register fields
`define OERS_CTRL_FUNC_LSB 0
`define OERS_CTRL_FUNC_MSB 2
`define OERS_CTRL_POL_BIT 4
`define OERS_CTRL_DIN_LSB 8
`define OERS_CTRL_DIN_MSB 10
`define OERS_ACK_BIT 0

// reset values
`define OERS_RST_FUNC 3'h1
`define OERS_RST_POL 1'h0
`define OERS_RST_DIN 3'h0
`define OERS_RST_SRC 16'h0000
`define OERS_RST_RSP 16'h0000
`define OERS_RST_INT_ENABLE 3'h0

// channel function codes
`define OERS_FUNC_NONE 3'h0
`define OERS_FUNC_DOUT 3'h1
`define OERS_FUNC_HEAT 3'h2
`define OERS_FUNC_COOL 3'h3
`define OERS_FUNC_DIN 3'h4

// digital input function codes
`define OERS_DIN_NONE 3'h0
`define OERS_DIN_ACK 3'h1
`define OERS_DIN_RSP_SEL 3'h4

// event source codes, code 0 is none
`define OERS_SRC_W 4
`define OERS_SRC_RFAIL 4'hA
`define OERS_SRC_PFAIL 4'hB

// interrupt status bits
`define OERS_INT_W 3
`define OERS_INT_RFAIL_SET 0
`define OERS_INT_RFAIL_CLR 1
`define OERS_INT_DIN_ACT 2

// remote setpoint watchdog timing
`define OERS_RSP_TIMEOUT_SEC 5
`define OERS_CLK_HZ 100000000

`endif

// *** hw/oers_rsp_watchdog.v ***
// remote setpoint write watchdog raising the comms-fail flag
module oers_rsp_watchdog #(
	parameter CNT_W = 29,
	parameter TIMEOUT_CYCLES = 500000000
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// write seen and flag
	input wire kick,
	output reg fail
);

	localparam [CNT_W-1:0] LAST = TIMEOUT_CYCLES - 1;

	reg [CNT_W-1:0] count;

	// count idle cycles, restart on every remote setpoint write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= {CNT_W{1'b0}};
			fail <= 1'b0;
		end else if (kick) begin
			count <= {CNT_W{1'b0}};
			fail <= 1'b0; // [R2]
		end else if (count == LAST) begin
			fail <= 1'b1; // [R1]
		end else begin
			count <= count + 1'b1;
		end
	end

endmodule // oers_rsp_watchdog

// *** sim/oers_channel_monitor.sv ***
// port checker for the event-routing channel
module oers_channel_monitor #(
	parameter int TIMEOUT_CYCLES = 50
) (
	// clock, reset and apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	// event sources
	input wire alarm_one_event,
	input wire alarm_two_event,
	input wire alarm_three_event,
	input wire alarm_four_event,
	input wire loop_break_alarm,
	input wire sensor_break_alarm,
	input wire timer_end_status,
	input wire timer_run_status,
	input wire manual_status,
	input wire programmer_event,
	input wire control_demand_on,
	// channel outputs
	input wire relay_drive,
	input wire remote_setpoint_select,
	input wire remote_comms_fail_flag,
	input wire power_fail_latched
);
	timeunit 1ns;
	timeprecision 1ps;
	logic done;
	logic evor;
	logic [10:0] ctrl;
	logic [15:0] src, quiet, tab;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// event table indexed by selector code, code 0 and 13-15 give nothing
	assign done = psel && penable && pready && pwrite;
	assign tab = {3'h0, programmer_event, power_fail_latched, remote_comms_fail_flag,
		manual_status, timer_run_status, timer_end_status, sensor_break_alarm,
		loop_break_alarm, alarm_four_event, alarm_three_event, alarm_two_event,
		alarm_one_event, 1'b0};
	assign evor = tab[src[3:0]] | tab[src[7:4]] | tab[src[11:8]] | tab[src[15:12]];
	// config shadow and cycles since the last setpoint write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 11'h001;
			src <= 16'h0000;
			quiet <= 16'h0000;
		end else begin
			if (done && paddr == 8'h00) ctrl <= pwdata[10:0];
			if (done && paddr == 8'h04) src <= pwdata[15:0];
			if (done && paddr == 8'h08) quiet <= 16'h0000;
			else if (quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
		end
	end
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_wait: assert property (psel && $rose(penable) |=> pready) else $error("no wait state");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_fail_not_early: assert property ($rose(remote_comms_fail_flag) |->
		quiet >= TIMEOUT_CYCLES - 1) else $error("fail flag early");
	a_fail_on_time: assert property (quiet == TIMEOUT_CYCLES + 3 |->
		remote_comms_fail_flag) else $error("fail flag late");
	a_fail_clears: assert property (done && paddr == 8'h08 |->
		##[1:3] !remote_comms_fail_flag) else $error("fail flag kept");
	a_pfail_ack: assert property (done && paddr == 8'h0C && pwdata[0] |->
		##[1:3] !power_fail_latched) else $error("power fail kept");
	a_pfail_stays: assert property (!power_fail_latched |=>
		!power_fail_latched) else $error("power fail reset");
	a_relay_heat: assert property (ctrl[2:1] == 2'h1 |=>
		relay_drive == $past(control_demand_on ^ ctrl[4])) else $error("heat drive");
	a_relay_events: assert property (ctrl[2:0] == 3'h1 |=>
		relay_drive == $past(evor ^ ctrl[4])) else $error("event drive");
	a_relay_off: assert property (ctrl[2:0] == 3'h0 || ctrl[2:0] == 3'h4 |=>
		!relay_drive) else $error("relay in idle");
	a_rsp_sel_gate: assert property ((ctrl[2:0] != 3'h4 || ctrl[10:8] != 3'h4) [*3] |->
		!remote_setpoint_select) else $error("select off mode");
endmodule // oers_channel_monitor

bind oers_channel oers_channel_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) oers_channel_monitor_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.alarm_one_event, .alarm_two_event, .alarm_three_event, .alarm_four_event,
	.loop_break_alarm, .sensor_break_alarm, .timer_end_status, .timer_run_status,
	.manual_status, .programmer_event, .control_demand_on, .relay_drive,
	.remote_setpoint_select, .remote_comms_fail_flag, .power_fail_latched);

// *** sim/oers_contact_model.sv ***
// external switch contact with a settable lag on both closing and opening
module oers_contact_model (
	// clock and command
	input wire logic pclk,
	input wire logic close_req,
	input wire logic [3:0] lag,
	// contact pin
	output logic contact_closed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	initial contact_closed = 1'b0;
	// pin follows the command only once the lag has run out
	always @(posedge pclk) begin
		if (close_req == contact_closed) cnt <= 4'h0;
		else if (cnt >= lag) contact_closed <= close_req;
		else cnt <= cnt + 4'h1;
	end
endmodule // oers_contact_model

// *** sim/tb_oers_channel.sv ***
// self-checking bench for the event-routing channel
`include "oers_defines.vh"
module tb_oers_channel;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [9:0] evr = 0;
	logic [3:0] lag = 0;
	logic [15:0] remote_setpoint_value;
	logic control_demand_on = 0, creq = 0, contact_closed, relay_drive, irq;
	logic remote_setpoint_select, remote_comms_fail_flag, power_fail_latched;
	logic [32:0] expq[$];
	int miscompares = 0, compares = 0;
	always #5 pclk = ~pclk;
	oers_channel #(.CNT_W(8), .TIMEOUT_CYCLES(50)) oers_channel_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .alarm_one_event(evr[0]), .alarm_two_event(evr[1]),
		.alarm_three_event(evr[2]), .alarm_four_event(evr[3]), .loop_break_alarm(evr[4]),
		.sensor_break_alarm(evr[5]), .timer_end_status(evr[6]), .timer_run_status(evr[7]),
		.manual_status(evr[8]), .programmer_event(evr[9]), .control_demand_on,
		.contact_closed, .relay_drive, .remote_setpoint_select, .remote_setpoint_value,
		.remote_comms_fail_flag, .power_fail_latched, .irq);
	oers_contact_model oers_contact_model_inst (.pclk, .close_req(creq), .lag, .contact_closed);
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int i;
		@(posedge pclk);
		expq.push_back(e);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
		{psel, penable} <= 2'h0;
		if (i == 20) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(0, a, 32'h0, {1'b0, e});
	endtask
	function automatic logic evx(input logic [15:0] s);
		logic [15:0] t;
		t = {3'h0, evr[9], 1'b1, 1'b0, evr[8:0], 1'b0};
		return t[s[3:0]] | t[s[7:4]] | t[s[11:8]] | t[s[15:12]];
	endfunction
	// answered accesses against the oldest noted expectation
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, expq.pop_front());
	end
	// main sequence
	initial begin
		logic [15:0] s;
		int i;
		void'($urandom(83518));
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd(`OERS_OFS_STATUS, 32'h4);
		rd(`OERS_OFS_CTRL, 32'h1);
		rd(`OERS_OFS_INT_ENABLE, 32'h0);
		acc(0, 8'h40, 32'h0, 33'h100000000);
		$display("test reset done");
		for (i = 0; i < 32; i++) begin
			s = 16'($urandom);
			s[3:0] = 4'(i);
			evr <= 10'($urandom);
			wr(`OERS_OFS_RSP, i);
			wr(`OERS_OFS_CTRL, {i[4], 4'h1});
			wr(`OERS_OFS_SRC, s);
			repeat (3) @(posedge pclk);
			chk(relay_drive, evx(s) ^ i[4]);
		end
		evr <= 10'h3FF;
		wr(`OERS_OFS_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		chk(relay_drive, 0);
		for (i = 0; i < 8; i++) begin
			control_demand_on <= i[2];
			wr(`OERS_OFS_CTRL, {i[1], 3'h1, i[0]});
			repeat (3) @(posedge pclk);
			chk(relay_drive, i[2] ^ i[1]);
		end
		$display("test routing done");
		wr(`OERS_OFS_RSP, 32'hA5C3);
		wr(`OERS_OFS_INT_CLEAR, 32'h7);
		rd(`OERS_OFS_RSP, 32'hA5C3);
		chk(remote_setpoint_value, 16'hA5C3);
		rd(`OERS_OFS_INT_STATUS, 32'h0);
		for (i = 0; i < 300 && remote_comms_fail_flag !== 1'b1; i++) @(posedge pclk);
		if (i == 300) chk(0, 1);
		if (i == 300) conclude();
		rd(`OERS_OFS_INT_STATUS, 32'h1);
		chk(irq, 0);
		wr(`OERS_OFS_INT_ENABLE, 32'h3);
		wr(`OERS_OFS_CTRL, 32'h1);
		wr(`OERS_OFS_SRC, 32'hA);
		repeat (3) @(posedge pclk);
		chk({irq, relay_drive}, 3);
		wr(`OERS_OFS_SRC, 32'h0);
		wr(`OERS_OFS_RSP, 32'h0);
		repeat (3) @(posedge pclk);
		chk(remote_comms_fail_flag, 0);
		wr(`OERS_OFS_INT_CLEAR, 32'h3);
		rd(`OERS_OFS_INT_STATUS, 32'h0);
		chk(irq, 0);
		$display("test watchdog done");
		for (i = 0; i < 4; i++) begin
			lag <= 4'($urandom_range(7));
			creq <= i[0];
			wr(`OERS_OFS_CTRL, {6'h20, i[1], 4'h4});
			repeat (20) @(posedge pclk);
			chk(remote_setpoint_select, i[0] ^ i[1]);
		end
		wr(`OERS_OFS_CTRL, 32'h1);
		wr(`OERS_OFS_SRC, 32'hB0);
		repeat (3) @(posedge pclk);
		chk(relay_drive, 1);
		wr(`OERS_OFS_ACK, 32'h1);
		repeat (3) @(posedge pclk);
		chk({relay_drive, power_fail_latched}, 0);
		$display("test input and power fail done");
		// mid-run reset re-arms the power-fail latch, then the input acknowledges it
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		creq <= 0;
		rd(`OERS_OFS_STATUS, 32'h4);
		repeat (20) @(posedge pclk);
		wr(`OERS_OFS_CTRL, 32'h104);
		creq <= 1;
		repeat (20) @(posedge pclk);
		chk({remote_setpoint_select, power_fail_latched}, 0);
		$display("test input acknowledge done");
		conclude();
	end
endmodule // tb_oers_channel
